/* File: hdl/srr_pkg.sv */
// Shared constants for the ramp synthesizer control register bank
package srr_pkg;
  // Bus offsets, byte addresses
  localparam logic [7:0] OFF_SHIFT = 8'h00;
  localparam logic [7:0] OFF_LOAD = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_CAPTURE = 8'h0c;
  localparam logic [7:0] OFF_FUNC = 8'h10;
  localparam logic [7:0] OFF_TEST = 8'h14;
  localparam logic [7:0] OFF_DELAY = 8'h18;
  // Control codes in word bits 2:0
  localparam logic [2:0] CODE_FUNC = 3'h3;
  localparam logic [2:0] CODE_TEST = 3'h4;
  localparam logic [2:0] CODE_DEV = 3'h5;
  localparam logic [2:0] CODE_STEP = 3'h6;
  localparam logic [2:0] CODE_DELAY = 3'h7;
  // Function word fields
  localparam int F_NSEL = 15;
  localparam int F_SKIP = 14;
  localparam int F_RMODE = 10;
  localparam int F_PSK = 9;
  localparam int F_FSK = 8;
  localparam int F_LDP = 7;
  localparam int F_POL = 6;
  localparam int F_PD = 5;
  localparam int F_CPTRI = 4;
  localparam int F_CRST = 3;
  // Test word fields
  localparam int T_SYNC = 31;
  localparam int T_SDM = 26;
  localparam int T_BLEED = 23;
  localparam int T_RDBK = 21;
  localparam int T_DIVM = 19;
  localparam int T_SECOND_CLOCK_DIVIDER = 7;
  localparam logic [4:0] SDM_OFF = 5'h0e;
  localparam logic [1:0] BLEED_ON = 2'h3;
  localparam logic [1:0] DIVM_RAMP = 2'h1;
  // Deviation, step and delay word fields
  localparam int D_TXCLK = 29;
  localparam int D_PAR = 28;
  localparam int D_IRQ = 26;
  localparam int D_FSKR = 25;
  localparam int D_RAMP2 = 24;
  localparam int D_SEL = 23;
  localparam int D_OFFS = 19;
  localparam int D_DEV = 3;
  localparam int S_SEL = 23;
  localparam int S_CNT = 3;
  localparam int Y_FL = 18;
  localparam int Y_RD = 17;
  localparam int Y_CLK = 16;
  localparam int Y_EN = 15;
  localparam int Y_CNT = 3;
  // Reset values
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  // Timing
  localparam int CLK_NS = 5;
  localparam int PFD_NS = 15;
  localparam int PFD_DIV = (PFD_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [5:0] LD_SHORT = 6'h18;
  localparam logic [5:0] LD_LONG = 6'h28;
  localparam logic [2:0] PIPE_DLY = 3'h4;
endpackage

/* File: hdl/srr_tick_div.sv */
// Programmable divider of an enable pulse stream
`timescale 1ns/1ps
module srr_tick_div (
  input wire logic pclk,            // System clock
  input wire logic presetn,         // Async reset, active low
  input wire logic clear,           // Restart count
  input wire logic tick_in,         // Input enable pulse
  input wire logic [11:0] divisor,  // Ticks per output, 0 acts as 1
  output logic tick_out             // One-cycle output pulse
);
  logic [11:0] cnt;
  logic last;

  assign last = (cnt + 12'h001 >= divisor);

  // Count input ticks, pulse on the last one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 12'h000;
      tick_out <= 1'b0;
    end else if (clear) begin
      cnt <= 12'h000;
      tick_out <= 1'b0;
    end else begin
      tick_out <= tick_in && last;
      if (tick_in) begin
        cnt <= last ? 12'h000 : cnt + 12'h001;
      end
    end
  end
endmodule

/* File: hdl/srr_ctrl.sv */
// Control register bank of the ramp synthesizer with APB access
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
// Overview of operation
// - word bits 2:0 pick the target register
// - delay integer load to match fractional load
// - reset modulator per int/frac write unless skipped
// - ramp type, phase and frequency keying enables
// - lock after 24 or 40 in-lock cycles
// - function bit 6 sets detector polarity
// - power-down loads counters, tristates pump, clears lock
// - function bit 4 tristates the charge pump
// - function bit 3 holds counters in reset
// - optionally sync load strobe to reference
// - modulator off code forces integer-only mode
// - bleed current never with readback active
// - test bits 22:21 enable frequency readback
// - divider mode and second clock divider
// - deviation bit 29 picks ramp clock source
// - parabolic, keying ramp and second ramp enables
// - transmit-data rise captures ramp position
// - two deviation words with offset and step
// - two 20-bit step count words
// - delay fast lock, ramp delay, delayed start
// - delay clock select and delayed start count
// - first divider sets ramp time step
// - hop interval is first times second divider
module srr_ctrl (
  input wire logic pclk,                         // System clock, 200 MHz
  input wire logic presetn,                      // Async reset, active low
  input wire logic psel,                         // APB select
  input wire logic penable,                      // APB enable
  input wire logic pwrite,                       // APB direction
  input wire logic [7:0] paddr,                  // APB byte address
  input wire logic [31:0] pwdata,                // APB write data
  output logic [31:0] prdata,                    // APB read data
  output logic pready,                           // APB ready
  output logic pslverr,                          // APB error
  input wire logic ref_pin,                      // Reference pin, async
  input wire logic in_lock_pin,                  // Phase in-lock pin, async
  input wire logic tx_data_pin,                  // Transmit-data pin, async
  input wire logic intfrac_write,                // Int/frac word latched
  input wire logic [11:0] first_clock_divider,   // First divider value
  output logic int_load,                         // Integer value load pulse
  output logic modulator_reset,                  // Modulator reset pulse
  output logic [1:0] ramp_mode,                  // Ramp waveform type
  output logic phase_keying,                     // Phase keying active
  output logic frequency_keying,                 // Frequency keying active
  output logic detector_polarity,                // 1 positive tuning
  output logic counter_load_force,               // Counters held at load state
  output logic counter_reset,                    // Counters held in reset
  output logic cp_tristate,                      // Charge pump high impedance
  output logic lock_detect,                      // Digital lock detect
  output logic sdm_disable,                      // Integer-only division
  output logic bleed_enable,                     // Negative bleed current on
  output logic readback_enable,                  // Readback on mux_output_pin
  output logic [1:0] div_mode,                   // Clock divider mode
  output logic parabolic_ramp_enable,            // Parabolic ramp on
  output logic fsk_ramp_enable,                  // Keying ramp on
  output logic ramp2_enable,                     // Second ramp on
  output logic [1:0] irq_type,                   // Interrupt type
  output logic [3:0] deviation_offset,           // Active deviation offset
  output logic [15:0] deviation_step,            // Active signed deviation
  output logic [19:0] step_count,                // Active step count
  output logic delay_fast_lock,                  // Ramp delay fast lock on
  output logic ramp_delay,                       // Ramp delay on
  output logic ramp_step_tick,                   // Ramp hop pulse
  output logic ramp_active                       // Ramp running after delay
);
  import srr_pkg::*;

  typedef enum logic [0:0] {LD_IDLE, LD_WAIT} srr_load_e;

  logic [31:0] shift_word, func_word, test_word, delay_word;
  logic [31:0] dev_word [2];
  logic [31:0] step_word [2];
  logic [1:0] ref_s, lock_s, tx_s;
  logic ref_d, tx_d, ref_rise, tx_rise;
  srr_load_e load_st;
  logic latch, wr, rd, load_req, deviation_word_select, step_sel;
  logic [1:0] pfd_cnt;
  logic pfd_tick, first_clock_divider_tick, hop_tick, delay_tick, ramp_on;
  logic [5:0] lock_cnt;
  logic [2:0] pipe_cnt;
  logic [11:0] dly_cnt;
  logic [19:0] step_idx, capture;
  logic cap_valid;

  // Register decode shared by read and write paths
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == OFF_SHIFT) || (a == OFF_LOAD) || (a == OFF_STATUS) ||
             (a == OFF_CAPTURE) || (a == OFF_FUNC) || (a == OFF_TEST) ||
             (a == OFF_DELAY);
  endfunction

  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped(paddr);
  assign load_req = wr && (paddr == OFF_LOAD);

  // Pin synchronisers, two flops each
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_s <= 2'h0;
      lock_s <= 2'h0;
      tx_s <= 2'h0;
      ref_d <= 1'b0;
      tx_d <= 1'b0;
    end else begin
      ref_s <= {ref_s[0], ref_pin};
      lock_s <= {lock_s[0], in_lock_pin};
      tx_s <= {tx_s[0], tx_data_pin};
      ref_d <= ref_s[1];
      tx_d <= tx_s[1];
    end
  end
  assign ref_rise = ref_s[1] && !ref_d;
  assign tx_rise = tx_s[1] && !tx_d;

  // Pending word written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_word <= WORD_RST;
    end else if (wr && paddr == OFF_SHIFT) begin
      shift_word <= pwdata;
    end
  end

  // Load strobe, optionally waiting for a reference edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_st <= LD_IDLE;
    end else begin
      unique case (load_st)
        LD_IDLE: begin
          if (load_req && test_word[T_SYNC] && !ref_rise) begin
            load_st <= LD_WAIT;
          end
        end
        LD_WAIT: begin
          if (ref_rise) begin
            load_st <= LD_IDLE;
          end
        end
      endcase
    end
  end
  assign latch = (load_st == LD_IDLE) ? load_req && (!test_word[T_SYNC] || ref_rise)
               : ref_rise;

  // Route a latched word by its control code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      func_word <= WORD_RST;
      test_word <= WORD_RST;
      delay_word <= WORD_RST;
      dev_word <= '{WORD_RST, WORD_RST};
      step_word <= '{WORD_RST, WORD_RST};
    end else if (latch) begin
      unique case (shift_word[2:0])
        CODE_FUNC: func_word <= shift_word;
        CODE_TEST: test_word <= shift_word;
        CODE_DEV: dev_word[shift_word[D_SEL]] <= shift_word;
        CODE_STEP: step_word[shift_word[S_SEL]] <= shift_word;
        CODE_DELAY: delay_word <= shift_word;
        default: ;
      endcase
    end
  end

  // Word selectors follow the last written select bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      deviation_word_select <= 1'b0;
      step_sel <= 1'b0;
    end else if (latch) begin
      if (shift_word[2:0] == CODE_DEV) deviation_word_select <= shift_word[D_SEL];
      if (shift_word[2:0] == CODE_STEP) step_sel <= shift_word[S_SEL];
    end
  end

  // Phase detector rate enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pfd_cnt <= 2'h0;
    end else begin
      pfd_cnt <= (pfd_cnt == 2'(PFD_DIV - 1)) ? 2'h0 : pfd_cnt + 2'h1;
    end
  end
  assign pfd_tick = (pfd_cnt == 2'(PFD_DIV - 1));

  // Lock detect counts consecutive in-lock cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_cnt <= 6'h00;
      lock_detect <= 1'b0;
    end else if (func_word[F_PD] || !lock_s[1]) begin
      lock_cnt <= 6'h00;
      lock_detect <= 1'b0;
    end else if (pfd_tick) begin
      if (lock_cnt != LD_LONG) lock_cnt <= lock_cnt + 6'h01;
      lock_detect <= (lock_cnt + 6'h01 >= (func_word[F_LDP] ? LD_LONG : LD_SHORT));
    end
  end

  // Integer load on each int/frac write, modulator reset unless skipped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pipe_cnt <= 3'h0;
      int_load <= 1'b0;
      modulator_reset <= 1'b0;
    end else begin
      modulator_reset <= intfrac_write && !func_word[F_SKIP];
      int_load <= 1'b0;
      if (intfrac_write) begin
        if (func_word[F_NSEL]) pipe_cnt <= PIPE_DLY;
        else int_load <= 1'b1;
      end else if (pipe_cnt != 3'h0 && pfd_tick) begin
        pipe_cnt <= pipe_cnt - 3'h1;
        int_load <= (pipe_cnt == 3'h1);
      end
    end
  end

  // Configuration outputs decoded from stored words
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ramp_mode <= 2'h0;
      phase_keying <= 1'b0;
      frequency_keying <= 1'b0;
      detector_polarity <= 1'b0;
      counter_load_force <= 1'b0;
      counter_reset <= 1'b0;
      cp_tristate <= 1'b0;
      sdm_disable <= 1'b0;
      bleed_enable <= 1'b0;
      readback_enable <= 1'b0;
      div_mode <= 2'h0;
    end else begin
      ramp_mode <= func_word[F_RMODE +: 2];
      phase_keying <= func_word[F_PSK] && !sdm_off_w();
      frequency_keying <= func_word[F_FSK] && !sdm_off_w();
      detector_polarity <= func_word[F_POL];
      counter_load_force <= func_word[F_PD];
      counter_reset <= func_word[F_CRST];
      cp_tristate <= func_word[F_CPTRI] || func_word[F_PD];
      sdm_disable <= sdm_off_w();
      bleed_enable <= (test_word[T_BLEED +: 2] == BLEED_ON) &&
                      (test_word[T_RDBK +: 2] == 2'h0);
      readback_enable <= (test_word[T_RDBK +: 2] != 2'h0);
      div_mode <= test_word[T_DIVM +: 2];
    end
  end

  function automatic logic sdm_off_w();
    sdm_off_w = (test_word[T_SDM +: 5] == SDM_OFF);
  endfunction

  // Ramp and delay fields of the selected words
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      parabolic_ramp_enable <= 1'b0;
      fsk_ramp_enable <= 1'b0;
      ramp2_enable <= 1'b0;
      irq_type <= 2'h0;
      deviation_offset <= 4'h0;
      deviation_step <= 16'h0000;
      step_count <= 20'h00000;
      delay_fast_lock <= 1'b0;
      ramp_delay <= 1'b0;
    end else begin
      parabolic_ramp_enable <= dev_word[deviation_word_select][D_PAR];
      fsk_ramp_enable <= dev_word[deviation_word_select][D_FSKR];
      ramp2_enable <= dev_word[deviation_word_select][D_RAMP2];
      irq_type <= dev_word[deviation_word_select][D_IRQ +: 2];
      deviation_offset <= dev_word[deviation_word_select][D_OFFS +: 4];
      deviation_step <= dev_word[deviation_word_select][D_DEV +: 16];
      step_count <= step_word[step_sel][S_CNT +: 20];
      delay_fast_lock <= delay_word[Y_FL];
      ramp_delay <= delay_word[Y_RD];
    end
  end

  // First divider sets the ramp time step
  srr_tick_div u_first_clock_divider (
    .pclk(pclk),
    .presetn(presetn),
    .clear(func_word[F_PD]),
    .tick_in(pfd_tick),
    .divisor(first_clock_divider),
    .tick_out(first_clock_divider_tick)
  );

  // Second divider chained for the hop interval
  srr_tick_div u_second_clock_divider (
    .pclk(pclk),
    .presetn(presetn),
    .clear(func_word[F_PD]),
    .tick_in(first_clock_divider_tick),
    .divisor(test_word[T_SECOND_CLOCK_DIVIDER +: 12]),
    .tick_out(hop_tick)
  );

  assign ramp_on = (test_word[T_DIVM +: 2] == DIVM_RAMP) && !sdm_off_w() &&
                   !func_word[F_PD] && !func_word[F_CRST];
  assign delay_tick = delay_word[Y_CLK] ? first_clock_divider_tick : pfd_tick;

  // Delayed start, counted on the selected delay clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly_cnt <= 12'h000;
      ramp_active <= 1'b0;
    end else if (!ramp_on) begin
      dly_cnt <= 12'h000;
      ramp_active <= 1'b0;
    end else if (!ramp_active) begin
      if (!delay_word[Y_EN] || dly_cnt >= delay_word[Y_CNT +: 12]) begin
        ramp_active <= 1'b1;
      end else if (delay_tick) begin
        dly_cnt <= dly_cnt + 12'h001;
      end
    end
  end

  // Ramp hop from divider chain or transmit-data clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ramp_step_tick <= 1'b0;
    end else begin
      ramp_step_tick <= ramp_active &&
                        (dev_word[deviation_word_select][D_TXCLK] ? tx_rise : hop_tick);
    end
  end

  // Step position and capture on transmit-data rise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_idx <= 20'h00000;
      capture <= 20'h00000;
      cap_valid <= 1'b0;
    end else begin
      if (!ramp_active) step_idx <= 20'h00000;
      else if (ramp_step_tick) begin
        step_idx <= (step_idx + 20'h00001 >= step_count) ? 20'h00000
                  : step_idx + 20'h00001;
      end
      if (tx_rise && irq_type != 2'h0) begin
        capture <= step_idx;
        cap_valid <= 1'b1;
      end else if (rd && paddr == OFF_CAPTURE) begin
        cap_valid <= 1'b0;
      end
    end
  end

  // Read multiplexer
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd) begin
      unique case (paddr)
        OFF_SHIFT: prdata = shift_word;
        OFF_STATUS: prdata = {27'h0, cap_valid, ramp_active, sdm_disable,
                              lock_detect, load_st == LD_WAIT};
        OFF_CAPTURE: prdata = {12'h000, capture};
        OFF_FUNC: prdata = func_word;
        OFF_TEST: prdata = test_word;
        OFF_DELAY: prdata = delay_word;
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

  sequence s_nsel_write;
    intfrac_write && func_word[F_NSEL];
  endsequence

  a_route_func: assert property (@(posedge pclk) disable iff (!presetn)
    latch && shift_word[2:0] == CODE_FUNC |=> func_word == $past(shift_word))
    else $error("function word not latched");
  a_int_delayed: assert property (@(posedge pclk) disable iff (!presetn)
    s_nsel_write |=> !int_load [*3])
    else $error("integer load not delayed");
  a_mod_reset: assert property (@(posedge pclk) disable iff (!presetn)
    intfrac_write |=> modulator_reset == !$past(func_word[F_SKIP]))
    else $error("modulator reset wrong");
  a_lock_pd: assert property (@(posedge pclk) disable iff (!presetn)
    func_word[F_PD] |=> !lock_detect && cp_tristate)
    else $error("power-down did not clear lock");
  a_lock_min: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(lock_detect) |-> lock_cnt >= (func_word[F_LDP] ? LD_LONG : LD_SHORT))
    else $error("lock detect too early");
  a_sync_wait: assert property (@(posedge pclk) disable iff (!presetn)
    test_word[T_SYNC] && !ref_rise |=> $stable(func_word) && $stable(test_word))
    else $error("load latched without reference edge");
  a_sdm_keying: assert property (@(posedge pclk) disable iff (!presetn)
    sdm_disable |-> !frequency_keying && !phase_keying && !ramp_active)
    else $error("keying active in integer mode");
  a_bleed_rdbk: assert property (@(posedge pclk) disable iff (!presetn)
    !(bleed_enable && readback_enable))
    else $error("bleed with readback");
  a_crst_hold: assert property (@(posedge pclk) disable iff (!presetn)
    func_word[F_CRST] |=> counter_reset && !ramp_active)
    else $error("counter reset not held");
endmodule

/* File: dv/srr_core_model.sv */
// Behavioural model of the synthesizer core beside the register bank
`timescale 1ns/1ps
module srr_core_model (
  input wire logic pclk,      // System clock
  input wire logic lock_on,   // Loop held in lock
  input wire logic frac_go,   // Int/frac word request
  output logic ref_pin,       // Reference square wave
  output logic in_lock_pin,   // Phase in-lock level
  output logic tx_data_pin,   // Transmit-data level
  output logic intfrac_write  // One-cycle latch pulse
);
  logic [5:0] div = 6'h00;
  // Free-running reference and slow transmit data edges
  always @(posedge pclk) begin
    div <= div + 6'h01;
    ref_pin <= div[2];
    tx_data_pin <= div[5];
  end
  // Lock level and a single-cycle int/frac latch pulse
  always_ff @(posedge pclk) begin
    in_lock_pin <= lock_on;
    intfrac_write <= frac_go & ~intfrac_write;
  end
endmodule

/* File: dv/srr_ctrl_bench.sv */
// Self-checking bench of the ramp synthesizer control register bank
`timescale 1ns/1ps
module srr_ctrl_bench;
  import srr_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [11:0] first_clock_divider = 12'h002;
  logic lock_on = 1'b0;
  logic frac_go = 1'b0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, ref_pin, in_lock_pin, tx_data_pin, intfrac_write;
  logic int_load, modulator_reset, phase_keying, frequency_keying, detector_polarity;
  logic counter_load_force, counter_reset, cp_tristate, lock_detect, sdm_disable;
  logic bleed_enable, readback_enable, parabolic_ramp_enable, fsk_ramp_enable;
  logic ramp2_enable, delay_fast_lock, ramp_delay, ramp_step_tick, ramp_active;
  logic [1:0] ramp_mode, div_mode, irq_type;
  logic [3:0] deviation_offset;
  logic [15:0] deviation_step;
  logic [19:0] step_count;
  int fail_count = 0;
  int cmp_count = 0;
  // Output groups compared as one value
  wire [6:0] fo = {ramp_mode, phase_keying, frequency_keying, detector_polarity,
    cp_tristate, counter_reset};
  wire [4:0] to = {sdm_disable, bleed_enable, readback_enable, div_mode};
  wire [24:0] dv = {parabolic_ramp_enable, irq_type, fsk_ramp_enable, ramp2_enable,
    deviation_offset, deviation_step};
  wire [2:0] pd = {counter_load_force, cp_tristate, lock_detect};

  always #2.5 pclk = ~pclk;

  srr_ctrl uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .ref_pin, .in_lock_pin, .tx_data_pin, .intfrac_write,
    .first_clock_divider, .int_load, .modulator_reset, .ramp_mode, .phase_keying,
    .frequency_keying, .detector_polarity, .counter_load_force, .counter_reset,
    .cp_tristate, .lock_detect, .sdm_disable, .bleed_enable, .readback_enable, .div_mode,
    .parabolic_ramp_enable, .fsk_ramp_enable, .ramp2_enable, .irq_type, .deviation_offset,
    .deviation_step, .step_count, .delay_fast_lock, .ramp_delay, .ramp_step_tick,
    .ramp_active);

  srr_core_model partner (.pclk, .lock_on, .frac_go, .ref_pin, .in_lock_pin,
    .tx_data_pin, .intfrac_write);

  // Counts and prints the verdict
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      chk(0, 1, "bus timeout");
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Shift a word in, then latch it with the load strobe
  task automatic ld(input logic [31:0] w);
    apb(1'b1, OFF_SHIFT, w);
    apb(1'b1, OFF_LOAD, 32'h0);
    repeat (2) @(posedge pclk);
  endtask

  task automatic t_reset();
    apb(1'b0, OFF_FUNC, 32'h0);
    chk(rd, WORD_RST, "func after reset");
    chk({fo, to, pd}, 15'h0, "outputs after reset");
  endtask

  // Power-up order: delay, both step words, both deviation words
  task automatic t_init();
    ld(32'h0000_0007);
    ld(32'h0000_0006);
    ld(32'h0080_0006);
    ld(32'h0000_0005);
    ld(32'h0080_0005);
    chk(dv, 25'h0, "deviation after init");
  endtask

  // Load held for a reference edge while sync is on
  task automatic t_sync();
    int n;
    ld(32'h8000_0004);
    apb(1'b1, OFF_SHIFT, 32'h0000_0043);
    for (n = 0; n < 40 && ref_pin !== 1'b0; n++) @(posedge pclk);
    for (n = 0; n < 40 && ref_pin !== 1'b1; n++) @(posedge pclk);
    @(posedge pclk);
    apb(1'b1, OFF_LOAD, 32'h0);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(rd[0], 1'b1, "load waits for reference");
    repeat (8) @(posedge pclk);
    apb(1'b0, OFF_FUNC, 32'h0);
    chk(rd, 32'h0000_0043, "synced load");
    ld(32'h0000_0004);
    repeat (10) @(posedge pclk);
  endtask

  task automatic t_func();
    ld(32'h0000_0a5b);
    chk(fo, 7'h57, "func fields a");
    ld(32'h0000_0503);
    chk(fo, 7'h28, "func fields b");
    apb(1'b1, OFF_SHIFT, 32'h0000_0a5b);
    repeat (3) @(posedge pclk);
    chk(fo, 7'h28, "shift without load");
    ld(32'h0000_0a58);
    apb(1'b0, OFF_FUNC, 32'h0);
    chk(rd, 32'h0000_0503, "code zero ignored");
  endtask

  task automatic t_test();
    ld(32'h3980_0004);
    chk(to, 5'h18, "modulator off and bleed");
    // Fraction words are zero outside this block; counter reset set then cleared
    ld(32'h0000_000b);
    chk(counter_reset, 1'b1, "integer mode counter reset");
    ld(32'h0000_0003);
    chk({counter_reset, sdm_disable}, 2'h1, "integer mode entered");
    ld(32'h0028_0004);
    chk(to, 5'h05, "readback and divider mode");
    apb(1'b0, OFF_TEST, 32'h0);
    chk(rd, 32'h0028_0004, "test word");
  endtask

  task automatic t_dev();
    ld(32'h1548_000d);
    chk(dv, 25'h159_0001, "deviation a");
    ld(32'h0a9b_fff5);
    chk(dv, 25'h0a3_7ffe, "deviation b");
    ld(32'h007f_fffe);
    chk(step_count, 20'hfffff, "steps a");
    ld(32'h0080_002e);
    chk(step_count, 20'h00005, "steps b");
    ld(32'h0006_055f);
    chk({delay_fast_lock, ramp_delay}, 2'h3, "delay bits");
    apb(1'b0, OFF_DELAY, 32'h0);
    chk(rd, 32'h0006_055f, "delay word");
  endtask

  // Cycles from in-lock to lock detect
  task automatic t_lock(input logic [31:0] w, input int lo, input int hi);
    int n;
    ld(w);
    lock_on <= 1'b0;
    repeat (10) @(posedge pclk);
    lock_on <= 1'b1;
    n = 0;
    while (lock_detect !== 1'b1 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    chk(n >= lo && n <= hi, 1, "lock delay");
  endtask

  task automatic t_pdown();
    ld(32'h0000_0023);
    chk(pd, 3'h6, "power down");
    apb(1'b0, OFF_TEST, 32'h0);
    chk(rd, 32'h0028_0004, "words kept");
    lock_on <= 1'b0;
  endtask

  // Int/frac latch: modulator reset and integer load timing
  task automatic t_frac(input logic [31:0] w, input logic mr, input int lo, input int hi);
    int n;
    int t;
    logic seen;
    ld(w);
    frac_go <= 1'b1;
    @(posedge pclk);
    frac_go <= 1'b0;
    t = 0;
    seen = 1'b0;
    for (n = 1; n <= 30; n++) begin
      @(posedge pclk);
      if (modulator_reset === 1'b1) seen = 1'b1;
      if (int_load === 1'b1 && t == 0) t = n;
    end
    chk(seen, mr, "modulator reset");
    chk(t >= lo && t <= hi, 1, "int load time");
  endtask

  // Gap between two hops with dividers 2 and 3
  task automatic t_hop();
    int n;
    int k;
    int t0;
    int t1;
    ld(32'h0008_0184);
    ld(32'h0000_0007);
    ld(32'h0000_0003);
    k = 0;
    t0 = 0;
    t1 = 0;
    for (n = 0; n < 300 && k < 2; n++) begin
      @(posedge pclk);
      if (ramp_step_tick === 1'b1) begin
        if (k == 0) t0 = n;
        else t1 = n;
        k++;
      end
    end
    chk(t1 - t0, 18, "hop interval");
    chk(ramp_active, 1'b1, "ramp running");
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(rd[4:3], 2'h3, "capture and ramp status");
    // Delayed start of 4 phase detector ticks, restarted by counter reset
    ld(32'h0000_8027);
    ld(32'h0000_000b);
    ld(32'h0000_0003);
    chk(ramp_active, 1'b0, "ramp start delayed");
    n = 0;
    while (ramp_active !== 1'b1 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    chk(n >= 8 && n <= 12, 1, "delayed start count");
  endtask

  task automatic t_bad();
    apb(1'b1, 8'h40, 32'hffff_ffff);
    chk(err, 1'b1, "unmapped write");
    apb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0, "unmapped read");
  endtask

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_init();
    t_func();
    t_sync();
    t_test();
    t_dev();
    t_lock(32'h0000_0003, 68, 84);
    t_lock(32'h0000_0083, 116, 132);
    t_pdown();
    t_frac(32'h0000_0003, 1'b1, 2, 5);
    t_frac(32'h0000_c003, 1'b0, 11, 20);
    t_hop();
    t_bad();
    conclude();
  end
endmodule
